/* bllpc_zero_count.sv */
// Shared constants and the run counter that spots three zero bytes on one link.
`timescale 1ns/1ps

package bllpc_pkg;
  // Byte values used while the link is being set up.
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] ACK_BYTE      = 8'h00;
  localparam logic [7:0] GENERIC_CODE  = 8'h55;
  localparam logic [7:0] BOOT_CODE     = 8'hC6;
  localparam logic [7:0] MAILBOX_MAGIC = 8'hA5;
  // Framing bytes of a command packet.
  localparam logic [7:0] CMD_START     = 8'h01;
  localparam logic [7:0] PKT_END       = 8'h03;
  localparam logic [7:0] SUM_GOOD      = 8'h00;
  // Number of consecutive zero bytes that selects a link.
  localparam int         ZERO_RUN      = 3;
  // Legal range of the length field: command byte plus 0 to 255 information bytes.
  localparam logic [15:0] LEN_MIN      = 16'h0001;
  localparam logic [15:0] LEN_MAX      = 16'h0100;
  localparam int          INFO_DEPTH   = 256;

  // Link that carries the session.
  typedef enum logic [1:0] {
    LINK_NONE  = 2'b00,
    LINK_UART  = 2'b01,
    LINK_USB   = 2'b10,
    LINK_DEBUG = 2'b11
  } bllpc_link_type;

  // Kind of error reported for a rejected packet.
  typedef enum logic [1:0] {
    ERR_NONE        = 2'b00,
    ERR_PACKET      = 2'b01,
    ERR_CHECKSUM    = 2'b10,
    ERR_UNSUPPORTED = 2'b11
  } bllpc_err_type;
endpackage

module bllpc_zero_count #(
  parameter int RUN = bllpc_pkg::ZERO_RUN
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic       own_valid,
  input  wire logic [7:0] own_data,
  input  wire logic       other_valid,
  output wire logic       run_done
);
  import bllpc_pkg::*;

  localparam int CW = $clog2(RUN + 1);

  // A run of one would make the counter meaningless.
  if (RUN < 2) begin : g_bad_run
    $error("bllpc_zero_count: RUN must be at least 2");
  end

  logic [CW-1:0] count_r;   // Zero bytes seen in a row on this link.
  logic [CW-1:0] count_nxt; // Next value of the run count.

  wire own_zero  = own_valid && (own_data == ZERO_BYTE);
  wire breaks    = !enable || other_valid || (own_valid && (own_data != ZERO_BYTE));

  // The last zero of the run completes it, unless the other link spoke in the same cycle.
  assign run_done  = enable && own_zero && !other_valid && (count_r == CW'(RUN - 1));
  // Any foreign byte or non-zero byte restarts the run.
  assign count_nxt = breaks ? '0 : (own_zero ? (run_done ? '0 : count_r + CW'(1)) : count_r);

  // The count only lives while detection is enabled.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // A byte on the other link wipes the run.
  chk_zero_cross_clear: assert property (@(posedge clock) disable iff (!nrst)
    (enable && other_valid) |=> (count_r == '0))
    else $error("zero run survived a byte on the other link");
endmodule

/* bllpc_boot_link.sv */
// Link setup and command packet screening for the serial programming boot path.
`timescale 1ns/1ps

// Overview of operation
// - Command phase only after generic code received.
// - Three zero bytes on UART select UART.
// - UART run cleared by nonzero or USB byte.
// - USB run cleared by nonzero or UART byte.
// - Answer three zeros with zero acknowledge byte.
// - Generic code 0x55 answered with boot code 0xC6.
// - Other bytes ignored while awaiting generic code.
// - Mode pin high, mailbox not magic: software reset.
// - Mode pin high, mailbox magic: debug link.
// - UART transmit line held high after init.
// - USB bytes counted only once configured.
// - Hunt for start byte, drop others.
// - Missing end byte gives packet error.
// - Bad checksum gives checksum error.
// - Bad length gives packet error.
// - Unknown command code gives unsupported error.
// - After error, no execution, await next packet.
// - After completion, stay in command phase.
// - Start byte 0x01, end byte 0x03.
// - Length, command, info and checksum sum zero.
// - Length high first, counts command plus info.
module bllpc_boot_link #(
  parameter int INFO_DEPTH = bllpc_pkg::INFO_DEPTH
) (
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     boot_mode_pin,
  input  wire logic [7:0]               debug_mailbox_mode_reg,
  input  wire logic                     usb_configured,
  input  wire logic                     uart_rx_valid,
  input  wire logic [7:0]               uart_rx_data,
  input  wire logic                     usb_rx_valid,
  input  wire logic [7:0]               usb_rx_data,
  input  wire logic                     dbg_rx_valid,
  input  wire logic [7:0]               dbg_rx_data,
  input  wire logic                     tx_ready,
  input  wire logic                     cmd_defined,
  input  wire logic                     cmd_len_ok,
  input  wire logic                     cmd_done,
  input  wire logic [7:0]               info_rd_addr,
  output logic                          uart_txd_high,
  output logic                          tx_valid,
  output logic [7:0]                    tx_data,
  output bllpc_pkg::bllpc_link_type     link_sel,
  output logic                          cmd_phase,
  output logic                          soft_reset_req,
  output logic                          err_valid,
  output bllpc_pkg::bllpc_err_type      err_code,
  output logic                          cmd_req_valid,
  output logic [7:0]                    cmd_code,
  output logic [7:0]                    cmd_info_len,
  output logic [7:0]                    info_rd_data
);
  import bllpc_pkg::*;

  // The information store is addressed by a byte, so it cannot be any other size.
  if (INFO_DEPTH != 256) begin : g_bad_depth
    $error("bllpc_boot_link: INFO_DEPTH must be 256");
  end

  // Main sequencer states: setup phase first, then packet screening.
  typedef enum logic [3:0] {
    S_INIT    = 4'h0,
    S_JUDGE   = 4'h1,
    S_DETECT  = 4'h2,
    S_ACK     = 4'h3,
    S_GENERIC = 4'h4,
    S_BOOT    = 4'h5,
    S_SOH     = 4'h6,
    S_LNH     = 4'h7,
    S_LNL     = 4'h8,
    S_CMD     = 4'h9,
    S_INFO    = 4'hA,
    S_SUM     = 4'hB,
    S_ETX     = 4'hC,
    S_CHECK   = 4'hD,
    S_EXEC    = 4'hE,
    S_RESET   = 4'hF
  } bllpc_state_type;

  bllpc_state_type state_r;          // Current sequencer state.
  bllpc_state_type state_nxt;        // Next sequencer state.
  bllpc_link_type  link_r;           // Link chosen for the session.
  bllpc_link_type  link_nxt;         // Next chosen link.
  bllpc_err_type   err_code_r;       // Last reported error kind.
  bllpc_err_type   err_nxt;          // Error kind chosen this cycle.
  logic [7:0]      lnh_r;            // Length high byte of the packet.
  logic [8:0]      len_r;            // Length field, 1 to 256 once the format check passes.
  logic [7:0]      cmd_r;            // Command code byte.
  logic [7:0]      sum_r;            // Running 8-bit sum over the checked bytes.
  logic [8:0]      info_cnt_r;       // Information bytes stored so far.
  logic            etx_ok_r;         // Last byte was the end byte.
  logic            tx_valid_r;       // Outgoing byte waiting for acceptance.
  logic [7:0]      tx_data_r;        // Outgoing byte.
  logic            txd_high_r;       // UART transmit line driven high.
  logic            cmd_phase_r;      // Command acceptable phase reached.
  logic            soft_reset_r;     // Software reset request pulse.
  logic            err_valid_r;      // Error report pulse.
  logic            cmd_req_r;        // Execution request pulse.
  logic [7:0]      info_len_r;       // Information byte count of the packet.
  logic [7:0]      info_rd_r;        // Registered information read data.
  logic [7:0]      info_mem [INFO_DEPTH]; // Information bytes of the packet.

  // Bytes of the chosen link; USB is deaf until it reports configured.
  wire usb_ok_valid = usb_rx_valid && usb_configured;
  wire rx_valid = (link_r == LINK_UART)  ? uart_rx_valid :
                  (link_r == LINK_USB)   ? usb_ok_valid  :
                  (link_r == LINK_DEBUG) ? dbg_rx_valid  : 1'b0;
  wire [7:0] rx_data = (link_r == LINK_USB)   ? usb_rx_data :
                       (link_r == LINK_DEBUG) ? dbg_rx_data : uart_rx_data;

  // Zero-run detection runs on both links at once until one of them wins.
  wire detecting = (state_r == S_DETECT);
  wire uart_hit;
  wire usb_hit;

  bllpc_zero_count #(.RUN(ZERO_RUN)) u_uart_run (
    .clock       (clock),
    .nrst        (nrst),
    .enable      (detecting),
    .own_valid   (uart_rx_valid),
    .own_data    (uart_rx_data),
    .other_valid (usb_ok_valid),
    .run_done    (uart_hit)
  );

  bllpc_zero_count #(.RUN(ZERO_RUN)) u_usb_run (
    .clock       (clock),
    .nrst        (nrst),
    .enable      (detecting),
    .own_valid   (usb_ok_valid),
    .own_data    (usb_rx_data),
    .other_valid (uart_rx_valid),
    .run_done    (usb_hit)
  );

  // Decoded conditions used by the sequencer.
  wire        mb_magic   = (debug_mailbox_mode_reg == MAILBOX_MAGIC);
  wire        tx_taken   = tx_valid_r && tx_ready;
  wire        got_byte   = rx_valid;
  wire [15:0] len_field  = {lnh_r, rx_data};
  wire        len_format = (len_field >= LEN_MIN) && (len_field <= LEN_MAX);
  wire        info_last  = ((info_cnt_r + 9'h002) == len_r);
  wire        sum_step   = got_byte && ((state_r == S_LNH) || (state_r == S_LNL) || (state_r == S_CMD) ||
                                        (state_r == S_INFO) || (state_r == S_SUM));
  wire        tx_load    = ((state_nxt == S_ACK) || (state_nxt == S_BOOT)) && (state_nxt != state_r);

  // Next-state logic for both phases.
  always_comb begin
    state_nxt = state_r;
    link_nxt  = link_r;
    err_nxt   = ERR_NONE;
    case (state_r)
      S_INIT: begin
        state_nxt = S_JUDGE;
      end
      S_JUDGE: begin
        if (boot_mode_pin && !mb_magic) begin
          state_nxt = S_RESET;
        end else if (boot_mode_pin) begin
          state_nxt = S_GENERIC;
          link_nxt  = LINK_DEBUG;
        end else begin
          state_nxt = S_DETECT;
        end
      end
      S_DETECT: begin
        // UART wins a tie; both runs can never end together, since each needs the other link silent.
        if (uart_hit) begin
          state_nxt = S_ACK;
          link_nxt  = LINK_UART;
        end else if (usb_hit) begin
          state_nxt = S_ACK;
          link_nxt  = LINK_USB;
        end
      end
      S_ACK: begin
        if (tx_taken) begin
          state_nxt = S_GENERIC;
        end
      end
      S_GENERIC: begin
        // Anything but the generic code is dropped here.
        if (got_byte && (rx_data == GENERIC_CODE)) begin
          state_nxt = S_BOOT;
        end
      end
      S_BOOT: begin
        if (tx_taken) begin
          state_nxt = S_SOH;
        end
      end
      S_SOH: begin
        if (got_byte && (rx_data == CMD_START)) begin
          state_nxt = S_LNH;
        end
      end
      S_LNH: begin
        if (got_byte) begin
          state_nxt = S_LNL;
        end
      end
      S_LNL: begin
        // A length outside the format leaves no way to find the packet's end, so reject at once.
        if (got_byte && !len_format) begin
          state_nxt = S_SOH;
          err_nxt   = ERR_PACKET;
        end else if (got_byte) begin
          state_nxt = S_CMD;
        end
      end
      S_CMD: begin
        if (got_byte) begin
          state_nxt = (len_r == 9'h001) ? S_SUM : S_INFO;
        end
      end
      S_INFO: begin
        if (got_byte && info_last) begin
          state_nxt = S_SUM;
        end
      end
      S_SUM: begin
        if (got_byte) begin
          state_nxt = S_ETX;
        end
      end
      S_ETX: begin
        if (got_byte) begin
          state_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        // Checks are made in a fixed order; the first failure is the one reported.
        state_nxt = S_SOH;
        if (!etx_ok_r) begin
          err_nxt = ERR_PACKET;
        end else if (sum_r != SUM_GOOD) begin
          err_nxt = ERR_CHECKSUM;
        end else if (!cmd_defined) begin
          err_nxt = ERR_UNSUPPORTED;
        end else if (!cmd_len_ok) begin
          err_nxt = ERR_PACKET;
        end else begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (cmd_done) begin
          state_nxt = S_SOH;
        end
      end
      S_RESET: begin
        state_nxt = S_RESET;
      end
      default: begin
        state_nxt = S_INIT;
      end
    endcase
  end

  // Sequencer, link choice and one-cycle event pulses.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r      <= S_INIT;
      link_r       <= LINK_NONE;
      err_valid_r  <= 1'b0;
      err_code_r   <= ERR_NONE;
      soft_reset_r <= 1'b0;
      cmd_req_r    <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      link_r       <= link_nxt;
      err_valid_r  <= (err_nxt != ERR_NONE);
      err_code_r   <= (err_nxt != ERR_NONE) ? err_nxt : err_code_r;
      soft_reset_r <= (state_nxt == S_RESET) && (state_r != S_RESET);
      cmd_req_r    <= (state_nxt == S_EXEC) && (state_r != S_EXEC);
    end
  end

  // Line levels and phase flag; the transmit line stays high from init onward.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txd_high_r  <= 1'b0;
      cmd_phase_r <= 1'b0;
    end else begin
      txd_high_r  <= txd_high_r || (state_r == S_INIT);
      cmd_phase_r <= cmd_phase_r || ((state_r == S_BOOT) && tx_taken);
    end
  end

  // Single-byte transmitter hand-off, held until the link accepts it.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= ACK_BYTE;
    end else if (tx_load) begin
      tx_valid_r <= 1'b1;
      tx_data_r  <= (state_nxt == S_ACK) ? ACK_BYTE : BOOT_CODE;
    end else if (tx_taken) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Packet field capture and checksum accumulation.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lnh_r      <= 8'h00;
      len_r      <= 9'h000;
      cmd_r      <= 8'h00;
      sum_r      <= 8'h00;
      info_cnt_r <= 9'h000;
      info_len_r <= 8'h00;
      etx_ok_r   <= 1'b0;
    end else begin
      if (state_r == S_SOH) begin
        sum_r <= 8'h00;
      end else if (sum_step) begin
        sum_r <= sum_r + rx_data;
      end
      if (got_byte && (state_r == S_LNH)) begin
        lnh_r <= rx_data;
      end
      if (got_byte && (state_r == S_LNL)) begin
        len_r      <= len_field[8:0];
        info_len_r <= 8'(len_field[8:0] - 9'h001);
      end
      if (got_byte && (state_r == S_CMD)) begin
        cmd_r      <= rx_data;
        info_cnt_r <= 9'h000;
      end
      if (got_byte && (state_r == S_INFO)) begin
        info_cnt_r <= info_cnt_r + 9'h001;
      end
      if (got_byte && (state_r == S_ETX)) begin
        etx_ok_r <= (rx_data == PKT_END);
      end
    end
  end

  // Information byte store; no reset, so entries not written by the current packet read back older or unknown bytes.
  always_ff @(posedge clock) begin
    if (got_byte && (state_r == S_INFO)) begin
      info_mem[info_cnt_r[7:0]] <= rx_data;
    end
    info_rd_r <= info_mem[info_rd_addr];
  end

  // All outputs come straight from flip-flops.
  assign uart_txd_high  = txd_high_r;
  assign tx_valid       = tx_valid_r;
  assign tx_data        = tx_data_r;
  assign link_sel       = link_r;
  assign cmd_phase      = cmd_phase_r;
  assign soft_reset_req = soft_reset_r;
  assign err_valid      = err_valid_r;
  assign err_code       = err_code_r;
  assign cmd_req_valid  = cmd_req_r;
  assign cmd_code       = cmd_r;
  assign cmd_info_len   = info_len_r;
  assign info_rd_data   = info_rd_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_ack_after_zeros: assert property ((detecting && uart_hit) |=>
    (tx_valid && (tx_data == ACK_BYTE) && (link_sel == LINK_UART)))
    else $error("no acknowledge after three UART zeros");
  chk_boot_code_reply: assert property ((state_r == S_GENERIC && rx_valid && rx_data == GENERIC_CODE) |=>
    (tx_valid && tx_data == BOOT_CODE && !cmd_phase))
    else $error("generic code not answered with boot code");
  chk_generic_discard: assert property ((state_r == S_GENERIC && rx_valid && rx_data != GENERIC_CODE) |=>
    (state_r == S_GENERIC && !tx_valid))
    else $error("setup phase left on a wrong byte");
  chk_soft_reset_req: assert property ((state_r == S_JUDGE && boot_mode_pin && !mb_magic) |=>
    soft_reset_req ##1 (!soft_reset_req && state_r == S_RESET))
    else $error("software reset not requested as a single pulse");
  chk_debug_select: assert property ((state_r == S_JUDGE && boot_mode_pin && mb_magic) |=>
    (link_sel == LINK_DEBUG && state_r == S_GENERIC))
    else $error("debug link not selected");
  chk_txd_idle_high: assert property ((state_r != S_INIT) |-> uart_txd_high)
    else $error("UART transmit line not high after init");
  chk_phase_entry: assert property ($rose(cmd_phase) |-> ($past(state_r) == S_BOOT && state_r == S_SOH))
    else $error("command phase entered without boot code");
  chk_soh_hunt: assert property ((state_r == S_SOH && rx_valid && rx_data != CMD_START) |=>
    (state_r == S_SOH))
    else $error("non-start byte left the hunt");
  chk_etx_error: assert property ((state_r == S_CHECK && !etx_ok_r) |=>
    (err_valid && err_code == ERR_PACKET && !cmd_req_valid))
    else $error("missing end byte not reported");
  chk_sum_error: assert property ((state_r == S_CHECK && etx_ok_r && sum_r != SUM_GOOD) |=>
    (err_valid && err_code == ERR_CHECKSUM))
    else $error("checksum error not reported");
  chk_unsup_error: assert property ((state_r == S_CHECK && etx_ok_r && sum_r == SUM_GOOD && !cmd_defined) |=>
    (err_valid && err_code == ERR_UNSUPPORTED))
    else $error("unsupported command not reported");
  chk_err_no_exec: assert property (err_valid |-> (!cmd_req_valid && state_r == S_SOH))
    else $error("command executed after an error");
  chk_exec_wait: assert property ((state_r == S_EXEC && !cmd_done) |=> (state_r == S_EXEC && !cmd_req_valid))
    else $error("new packet taken before completion");

  cov_uart_session: cover property (cmd_phase && link_sel == LINK_UART);
  cov_usb_session: cover property (cmd_phase && link_sel == LINK_USB);
  cov_good_packet: cover property (cmd_req_valid && cmd_info_len != 8'h00);
  cov_error_report: cover property (err_valid && err_code == ERR_CHECKSUM);
endmodule

/* bllpc_host_model.sv */
// Host-side model: transmit handshake, command table answers and execution timing.
`timescale 1ns/1ps
module bllpc_host_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       tx_valid,
  input  wire logic       cmd_req_valid,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_info_len,
  output logic            tx_ready,
  output logic            cmd_defined,
  output logic            cmd_len_ok,
  output logic            cmd_done
);
  logic [1:0] wait_r; // Cycles the pending byte has waited so far.
  logic [2:0] exec_r; // Delay line from request to completion.
  // A slow transmitter takes each byte on its third cycle, so the byte must stand.
  assign tx_ready = tx_valid && (wait_r == 2'h2);
  // Code 0xEE is missing from the table.
  assign cmd_defined = (cmd_code != 8'hEE);
  // An information length of 7 never fits a command.
  assign cmd_len_ok = (cmd_info_len != 8'h07);
  assign cmd_done = exec_r[2];
  // Count waiting cycles and delay the completion answer.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 2'h0;
      exec_r <= 3'h0;
    end else begin
      wait_r <= (tx_valid && !tx_ready) ? wait_r + 2'h1 : 2'h0;
      exec_r <= {exec_r[1:0], cmd_req_valid};
    end
  end
endmodule

/* testbench.sv */
// Self-checking testbench for the boot link setup and packet screening block.
`timescale 1ns/1ps
module testbench;
  import bllpc_pkg::*;
  logic           clock, nrst, boot_mode_pin, usb_configured, uart_rx_valid, usb_rx_valid, dbg_rx_valid;
  logic [7:0]     debug_mailbox_mode_reg, rx_data, info_rd_addr, tx_data, cmd_code, cmd_info_len, info_rd_data;
  logic           tx_ready, cmd_defined, cmd_len_ok, cmd_done, uart_txd_high, tx_valid, cmd_phase;
  logic           soft_reset_req, err_valid, cmd_req_valid, seen_sr;
  logic [2:0]     ev;
  bllpc_link_type link_sel;
  bllpc_err_type  err_code;
  int             n_fail, total_checks;
  bllpc_boot_link DUT (.clock, .nrst, .boot_mode_pin, .debug_mailbox_mode_reg, .usb_configured,
    .uart_rx_valid, .uart_rx_data(rx_data), .usb_rx_valid, .usb_rx_data(rx_data), .dbg_rx_valid,
    .dbg_rx_data(rx_data), .tx_ready, .cmd_defined, .cmd_len_ok, .cmd_done, .info_rd_addr, .uart_txd_high,
    .tx_valid, .tx_data, .link_sel, .cmd_phase, .soft_reset_req, .err_valid, .err_code, .cmd_req_valid,
    .cmd_code, .cmd_info_len, .info_rd_data);
  bllpc_host_model host (.clock, .nrst, .tx_valid, .cmd_req_valid, .cmd_code, .cmd_info_len, .tx_ready,
    .cmd_defined, .cmd_len_ok, .cmd_done);
  // Free-running 25 MHz clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Prints the counts and the verdict, then stops.
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Resets with the given mode pin, mailbox and USB state; notes any soft reset pulse.
  task automatic rst(input logic md, input logic [7:0] mb, input logic cfg);
    @(posedge clock);
    nrst <= 1'b0;
    boot_mode_pin <= md;
    debug_mailbox_mode_reg <= mb;
    usb_configured <= cfg;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    seen_sr = 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1 seen_sr |= soft_reset_req;
    end
  endtask
  // Sends one byte on link 0 UART, 1 USB or 2 debug; the gap cycle keeps each strobe a clean pulse.
  task automatic send(input int l, input logic [7:0] b);
    @(posedge clock);
    rx_data <= b;
    uart_rx_valid <= (l == 0);
    usb_rx_valid <= (l == 1);
    dbg_rx_valid <= (l == 2);
    @(posedge clock);
    uart_rx_valid <= 1'b0;
    usb_rx_valid <= 1'b0;
    dbg_rx_valid <= 1'b0;
  endtask
  // Waits for an outgoing byte, checks it and waits until the slow host has taken it.
  task automatic wait_tx(input logic [7:0] exp);
    int i;
    for (i = 0; i < 30 && !(tx_valid === 1'b1); i++) @(posedge clock) #1;
    if (i == 30) begin
      n_fail++;
      conclude;
    end
    chk("tx_data", tx_data, exp);
    for (i = 0; i < 30 && tx_valid !== 1'b0; i++) @(posedge clock) #1;
    // A byte the host never takes is a hang, not a pass.
    if (i == 30) begin
      n_fail++;
      conclude;
    end
  endtask
  // Sends a command packet on UART; bad spoils the checksum; ev returns request bit and error code.
  task automatic pkt(input logic [7:0] cmd, input logic [8:0] ln, input logic bad, input logic [7:0] packet_end_byte);
    logic [7:0] s;
    s = ln[7:0] + {7'h00, ln[8]} + cmd;
    repeat (6) @(posedge clock);
    send(0, CMD_START);
    send(0, {7'h00, ln[8]});
    send(0, ln[7:0]);
    // A length outside the format is refused at the low length byte, so nothing more is sent.
    if (ln != 9'h000 && ln <= 9'h100) begin
      send(0, cmd);
      for (int i = 0; i < ln - 1; i++) begin
        send(0, 8'h10 + i[7:0]);
        s = s + 8'h10 + i[7:0];
      end
      send(0, 8'h00 - s + {7'h00, bad});
      send(0, packet_end_byte);
    end
    ev = 3'h0;
    // Look first in the cycle of the last byte, since a length error answers one edge after it.
    for (int i = 0; i < 20 && ev == 3'h0; i++) begin
      #1 ev = {cmd_req_valid, err_valid ? err_code : ERR_NONE};
      if (ev == 3'h0) @(posedge clock);
    end
    if (ev == 3'h0) begin
      n_fail++;
      conclude;
    end
  endtask
  // Hang guard.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude;
  end
  // Main sequence.
  initial begin
    {nrst, boot_mode_pin, usb_configured, uart_rx_valid, usb_rx_valid, dbg_rx_valid} = 6'h00;
    {debug_mailbox_mode_reg, rx_data, info_rd_addr} = 24'h00_0000;
    rst(1'b0, 8'h00, 1'b1);
    chk("txd_high", uart_txd_high, 1'b1);
    // Runs broken by a nonzero UART byte and by a USB byte never select a link.
    send(0, 8'h00); send(0, 8'h00); send(0, 8'h07); send(0, 8'h00); send(0, 8'h00); send(1, 8'h00);
    send(0, 8'h00); send(0, 8'h00);
    repeat (2) @(posedge clock) #1;
    chk("no_ack", tx_valid, 1'b0);
    send(0, 8'h00);
    wait_tx(ACK_BYTE);
    chk("link_uart", link_sel, LINK_UART);
    send(0, 8'h12);
    repeat (3) @(posedge clock) #1;
    chk("stray_byte", {tx_valid, cmd_phase}, 2'h0);
    send(0, GENERIC_CODE);
    wait_tx(BOOT_CODE);
    repeat (2) @(posedge clock) #1;
    chk("cmd_phase", cmd_phase, 1'b1);
    // Junk before the start byte, then a good packet with two information bytes.
    send(0, 8'h33);
    pkt(8'h20, 9'h003, 1'b0, PKT_END);
    chk("good_pkt", {ev, cmd_code, cmd_info_len}, {3'h4, 8'h20, 8'h02});
    @(posedge clock);
    info_rd_addr <= 8'h01;
    repeat (2) @(posedge clock) #1;
    chk("info", info_rd_data, 8'h11);
    // Each error kind, then a good packet again.
    pkt(8'h20, 9'h003, 1'b0, 8'h02); chk("no_end", ev, {1'b0, ERR_PACKET});
    pkt(8'h20, 9'h003, 1'b1, PKT_END); chk("bad_sum", ev, {1'b0, ERR_CHECKSUM});
    pkt(8'hEE, 9'h001, 1'b0, PKT_END); chk("bad_cmd", ev, {1'b0, ERR_UNSUPPORTED});
    pkt(8'h20, 9'h008, 1'b0, PKT_END); chk("cmd_len", ev, {1'b0, ERR_PACKET});
    pkt(8'h20, 9'h101, 1'b0, PKT_END); chk("len_big", ev, {1'b0, ERR_PACKET});
    pkt(8'h20, 9'h000, 1'b0, PKT_END); chk("len_zero", ev, {1'b0, ERR_PACKET});
    pkt(8'h20, 9'h001, 1'b0, PKT_END); chk("again", {ev, cmd_info_len}, {3'h4, 8'h00});
    // USB bytes are ignored until configured; a UART byte breaks a USB run.
    rst(1'b0, 8'h00, 1'b0);
    send(1, 8'h00); send(1, 8'h00); send(1, 8'h00);
    repeat (2) @(posedge clock) #1;
    chk("usb_unconf", tx_valid, 1'b0);
    @(posedge clock);
    usb_configured <= 1'b1;
    send(1, 8'h00); send(1, 8'h00); send(0, 8'h00); send(1, 8'h00); send(1, 8'h00);
    repeat (2) @(posedge clock) #1;
    chk("usb_broken", tx_valid, 1'b0);
    send(1, 8'h00);
    wait_tx(ACK_BYTE);
    chk("link_usb", link_sel, LINK_USB);
    // Mode pin high: software reset without the magic value, debug link with it.
    rst(1'b1, 8'h00, 1'b0);
    chk("soft_rst", seen_sr, 1'b1);
    rst(1'b1, MAILBOX_MAGIC, 1'b0);
    chk("dbg_link", {seen_sr, link_sel}, {1'b0, LINK_DEBUG});
    send(2, GENERIC_CODE);
    wait_tx(BOOT_CODE);
    conclude;
  end
endmodule
